/* sahc_axis.sv */
// Axis control: homing, limits, resolution, triggers, joystick and persisted settings.
//
// Notes on behaviour
// RULE1 - Homing moves in the configured direction.
// RULE2 - Chosen limit switch defines home reference.
// RULE3 - Home lies at offset from switch.
// RULE4 - Homing speed capped by homing velocity.
// RULE5 - Homing uses ordinary min velocity, acceleration.
// RULE6 - Limit switch makes, breaks or ignored.
// RULE7 - Steps per rev accepted 1..10000 only.
// RULE8 - Gearbox ratio accepted 1..1000 only.
// RULE9 - Microstep calibration uses factor 128.
// RULE10 - Persisted settings restored at power-up.
// RULE11 - Disabled trigger mode: no trigger action.
// RULE12 - Trigger-in rising edge starts preselected move.
// RULE13 - In/out mode also pulses trigger out.
// RULE14 - Trigger-out mode pulses on host moves.
// RULE15 - Triggered move kind uses preloaded parameters.
// RULE16 - Joystick capped by gear velocity, acceleration.
// RULE17 - Joystick direction inverted when sense reversed.
// RULE18 - Joystick moves always trapezoidal.
// RULE19 - Bow index zero trapezoid, 1..18 S-curve.
// RULE20 - Trigger input synchronised, one edge one move.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
module sahc_axis #(
  parameter int AW = 8
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Switches and trigger pins, asynchronous.
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic trig_in,
  output logic trig_out,
  // Joystick from the handset decoder, same clock.
  input wire logic joy_active,
  input wire logic joy_dir,
  input wire logic joy_high_gear,
  // Non-volatile store of persisted words, same clock.
  input wire logic [31:0] nv_ctrl,
  input wire logic [31:0] nv_home_vel,
  input wire logic nv_valid,
  output logic nv_save,
  // Trajectory generator interface.
  output logic move_start,
  output logic [1:0] move_kind,
  output logic [31:0] move_target,
  output logic move_dir,
  output logic [31:0] vel_min,
  output logic [31:0] vel_max,
  output logic [31:0] accel,
  output logic s_curve,
  output logic [4:0] bow_index,
  input wire logic move_done,
  output logic axis_stop,
  output logic [31:0] pos_zero_load,
  output logic pos_zero_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [31:0] ctrl, home_vel, home_ofs, prof_min, prof_max, prof_acc;
    logic [31:0] rel_dist, abs_pos, steps_rev, gearbox, pitch, ustep_cal;
    logic [31:0] jlo_vel, jhi_vel, jlo_acc, jhi_acc;
    logic [31:0] rdata;
    logic wr_pend;
    logic [AW-1:0] wr_addr;
    logic [2:0] fwd_s, rev_s, trg_s;
    logic boot_done;
    sahc_pkg::sahc_ax_e ax;
    logic [7:0] pulse_cnt;
    logic start;
    logic [1:0] kind;
    logic dir;
    logic [31:0] target;
    logic zero_strobe;
    logic save;
  } sahc_state_s;

  sahc_state_s st_reg;
  sahc_state_s st_next;

  // Switch level to active flag per its configured sense.
  function automatic logic sahc_sw_active(input logic lvl, input logic [1:0] mode);
    case (mode)
      sahc_pkg::SW_MAKES: sahc_sw_active = lvl; // RULE6
      sahc_pkg::SW_BREAKS: sahc_sw_active = ~lvl; // RULE6
      default: sahc_sw_active = 1'b0; // RULE6
    endcase
  endfunction

  // Range check shared by the resolution registers.
  function automatic logic sahc_in_range(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    sahc_in_range = (v >= lo) && (v <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields.
  logic home_dir, home_sw, joy_inv, fwd_act, rev_act, home_hit, trg_edge;
  logic [1:0] trig_mode, move_sel;
  logic [4:0] bow;
  logic [AW-1:0] a;

  assign home_dir = st_reg.ctrl[sahc_pkg::CTRL_HOME_DIR];
  assign home_sw = st_reg.ctrl[sahc_pkg::CTRL_HOME_SW];
  assign trig_mode = st_reg.ctrl[sahc_pkg::CTRL_TRIG_LO +: 2];
  assign move_sel = st_reg.ctrl[sahc_pkg::CTRL_MOVE_LO +: 2];
  assign joy_inv = st_reg.ctrl[sahc_pkg::CTRL_JOY_INV];
  assign bow = st_reg.ctrl[sahc_pkg::CTRL_BOW_LO +: sahc_pkg::CTRL_BOW_W];
  assign fwd_act = sahc_sw_active(st_reg.fwd_s[1], st_reg.ctrl[sahc_pkg::CTRL_FWD_LIM_LO +: 2]);
  assign rev_act = sahc_sw_active(st_reg.rev_s[1], st_reg.ctrl[sahc_pkg::CTRL_REV_LIM_LO +: 2]);
  // The chosen switch is the home reference.
  assign home_hit = home_sw ? fwd_act : rev_act; // RULE2
  // Edge taken from second and third stages only, so one edge is one move.
  assign trg_edge = st_reg.trg_s[1] & ~st_reg.trg_s[2]; // RULE20
  assign a = st_reg.wr_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic host_go, trig_go;
    logic [1:0] host_kind;
    logic [AW-1:0] ra;
    st_next = st_reg;
    host_go = 1'b0;
    trig_go = 1'b0;
    host_kind = sahc_pkg::MOVE_REL;
    ra = haddr[AW-1:0];
    st_next.start = 1'b0;
    st_next.zero_strobe = 1'b0;
    st_next.save = 1'b0;
    st_next.fwd_s = {st_reg.fwd_s[1:0], fwd_limit_in};
    st_next.rev_s = {st_reg.rev_s[1:0], rev_limit_in};
    st_next.trg_s = {st_reg.trg_s[1:0], trig_in}; // RULE20
    if (st_reg.pulse_cnt != 8'h00) begin
      st_next.pulse_cnt = st_reg.pulse_cnt - 8'h01;
    end
    // Restore persisted words once after reset when the store holds them.
    if (!st_reg.boot_done) begin
      st_next.boot_done = 1'b1;
      if (nv_valid) begin
        st_next.ctrl = nv_ctrl; // RULE10
        st_next.home_vel = nv_home_vel; // RULE10
      end
    end
    // Address phase capture; every transfer completes with no wait state.
    st_next.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        st_next.wr_pend = 1'b1;
        st_next.wr_addr = ra;
      end else if (ra == sahc_pkg::OFF_CTRL) begin
        st_next.rdata = st_reg.ctrl;
      end else if (ra == sahc_pkg::OFF_HOME_VEL) begin
        st_next.rdata = st_reg.home_vel;
      end else if (ra == sahc_pkg::OFF_HOME_OFS) begin
        st_next.rdata = st_reg.home_ofs;
      end else if (ra == sahc_pkg::OFF_PROF_MIN) begin
        st_next.rdata = st_reg.prof_min;
      end else if (ra == sahc_pkg::OFF_PROF_MAX) begin
        st_next.rdata = st_reg.prof_max;
      end else if (ra == sahc_pkg::OFF_PROF_ACC) begin
        st_next.rdata = st_reg.prof_acc;
      end else if (ra == sahc_pkg::OFF_REL_DIST) begin
        st_next.rdata = st_reg.rel_dist;
      end else if (ra == sahc_pkg::OFF_ABS_POS) begin
        st_next.rdata = st_reg.abs_pos;
      end else if (ra == sahc_pkg::OFF_STEPS_REV) begin
        st_next.rdata = st_reg.steps_rev;
      end else if (ra == sahc_pkg::OFF_GEARBOX) begin
        st_next.rdata = st_reg.gearbox;
      end else if (ra == sahc_pkg::OFF_JOY_LO_VEL) begin
        st_next.rdata = st_reg.jlo_vel;
      end else if (ra == sahc_pkg::OFF_JOY_HI_VEL) begin
        st_next.rdata = st_reg.jhi_vel;
      end else if (ra == sahc_pkg::OFF_JOY_LO_ACC) begin
        st_next.rdata = st_reg.jlo_acc;
      end else if (ra == sahc_pkg::OFF_JOY_HI_ACC) begin
        st_next.rdata = st_reg.jhi_acc;
      end else if (ra == sahc_pkg::OFF_STATUS) begin
        st_next.rdata = {24'h000000, st_reg.trg_s[1], rev_act, fwd_act,
                         st_reg.pulse_cnt != 8'h00, st_reg.boot_done, 1'b0, st_reg.ax};
      end else if (ra == sahc_pkg::OFF_PITCH) begin
        st_next.rdata = st_reg.pitch;
      end else if (ra == sahc_pkg::OFF_USTEP_CAL) begin
        st_next.rdata = st_reg.ustep_cal;
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
    // Data phase of a write.
    if (st_reg.wr_pend) begin
      if (a == sahc_pkg::OFF_CTRL) begin
        st_next.ctrl = hwdata;
      end else if (a == sahc_pkg::OFF_HOME_VEL) begin
        st_next.home_vel = hwdata;
      end else if (a == sahc_pkg::OFF_HOME_OFS) begin
        st_next.home_ofs = hwdata;
      end else if (a == sahc_pkg::OFF_PROF_MIN) begin
        st_next.prof_min = hwdata;
      end else if (a == sahc_pkg::OFF_PROF_MAX) begin
        st_next.prof_max = hwdata;
      end else if (a == sahc_pkg::OFF_PROF_ACC) begin
        st_next.prof_acc = hwdata;
      end else if (a == sahc_pkg::OFF_REL_DIST) begin
        st_next.rel_dist = hwdata; // RULE15
      end else if (a == sahc_pkg::OFF_ABS_POS) begin
        st_next.abs_pos = hwdata; // RULE15
      end else if (a == sahc_pkg::OFF_STEPS_REV) begin
        // Out of range values are dropped and the old setting stands.
        if (sahc_in_range(hwdata, sahc_pkg::STEPS_REV_MIN, sahc_pkg::STEPS_REV_MAX)) begin
          st_next.steps_rev = hwdata; // RULE7
        end
      end else if (a == sahc_pkg::OFF_GEARBOX) begin
        if (sahc_in_range(hwdata, sahc_pkg::GEARBOX_MIN, sahc_pkg::GEARBOX_MAX)) begin
          st_next.gearbox = hwdata; // RULE8
        end
      end else if (a == sahc_pkg::OFF_JOY_LO_VEL) begin
        st_next.jlo_vel = hwdata;
      end else if (a == sahc_pkg::OFF_JOY_HI_VEL) begin
        st_next.jhi_vel = hwdata;
      end else if (a == sahc_pkg::OFF_JOY_LO_ACC) begin
        st_next.jlo_acc = hwdata;
      end else if (a == sahc_pkg::OFF_JOY_HI_ACC) begin
        st_next.jhi_acc = hwdata;
      end else if (a == sahc_pkg::OFF_PITCH) begin
        st_next.pitch = hwdata;
      end else if (a == sahc_pkg::OFF_CMD) begin
        st_next.save = hwdata[sahc_pkg::CMD_SAVE];
        if (hwdata[sahc_pkg::CMD_HOME]) begin
          host_go = 1'b1;
          host_kind = sahc_pkg::MOVE_HOME;
        end else if (hwdata[sahc_pkg::CMD_ABS]) begin
          host_go = 1'b1;
          host_kind = sahc_pkg::MOVE_ABS;
        end else if (hwdata[sahc_pkg::CMD_REL]) begin
          host_go = 1'b1;
          host_kind = sahc_pkg::MOVE_REL;
        end
      end
    end
    // Microsteps per output turn; recomputed every cycle, low 32 bits kept.
    st_next.ustep_cal = st_reg.steps_rev * st_reg.gearbox * 32'(sahc_pkg::USTEP_FACTOR); // RULE9
    // Trigger input only acts in the two input modes.
    trig_go = trg_edge && (trig_mode == sahc_pkg::TRIG_IN ||
                           trig_mode == sahc_pkg::TRIG_INOUT); // RULE11 RULE12
    // A new move is only taken when the axis is idle.
    if (st_reg.ax == sahc_pkg::AX_IDLE && (host_go || trig_go)) begin
      st_next.kind = host_go ? host_kind : (trig_go ? move_sel : host_kind); // RULE15
      if (st_next.kind == sahc_pkg::MOVE_RSV) begin
        st_next.kind = sahc_pkg::MOVE_REL;
      end
      if (st_next.kind == sahc_pkg::MOVE_HOME) begin
        st_next.ax = sahc_pkg::AX_SEEK;
        st_next.dir = home_dir; // RULE1
        st_next.target = 32'h0000_0000;
      end else begin
        st_next.ax = sahc_pkg::AX_MOVE;
        st_next.dir = 1'b0;
        st_next.target = (st_next.kind == sahc_pkg::MOVE_ABS) ? st_reg.abs_pos
                                                               : st_reg.rel_dist; // RULE15
      end
      st_next.start = 1'b1;
      // Output pulse: host moves in out mode, triggered moves in in/out mode.
      if ((host_go && trig_mode == sahc_pkg::TRIG_OUT) ||
          (!host_go && trig_mode == sahc_pkg::TRIG_INOUT)) begin
        st_next.pulse_cnt = sahc_pkg::TRIG_PULSE_CYC; // RULE13 RULE14
      end
    end
    // Homing sequence: seek reference, then travel the offset.
    case (st_reg.ax)
      sahc_pkg::AX_SEEK: begin
        if (home_hit) begin
          st_next.ax = sahc_pkg::AX_OFFSET; // RULE2
          st_next.dir = ~home_dir;
          st_next.kind = sahc_pkg::MOVE_REL;
          st_next.target = st_reg.home_ofs; // RULE3
          st_next.start = 1'b1;
        end
      end
      sahc_pkg::AX_OFFSET: begin
        if (move_done) begin
          st_next.ax = sahc_pkg::AX_IDLE;
          st_next.zero_strobe = 1'b1; // RULE3
        end
      end
      sahc_pkg::AX_MOVE: begin
        if (move_done) begin
          st_next.ax = sahc_pkg::AX_IDLE;
        end
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.ctrl <= sahc_pkg::CTRL_RESET;
      st_reg.steps_rev <= sahc_pkg::STEPS_REV_RESET;
      st_reg.gearbox <= sahc_pkg::GEARBOX_RESET;
      st_reg.pitch <= sahc_pkg::PITCH_RESET;
      st_reg.ax <= sahc_pkg::AX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  logic homing, joy_run;
  assign homing = (st_reg.ax == sahc_pkg::AX_SEEK) || (st_reg.ax == sahc_pkg::AX_OFFSET);
  assign joy_run = joy_active && (st_reg.ax == sahc_pkg::AX_IDLE);
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign trig_out = (st_reg.pulse_cnt != 8'h00) && (trig_mode != sahc_pkg::TRIG_OFF); // RULE11
  assign nv_save = st_reg.save;
  assign move_start = st_reg.start;
  assign move_kind = st_reg.kind;
  assign move_target = st_reg.target;
  // Joystick direction follows the sense setting.
  assign move_dir = joy_run ? (joy_dir ^ joy_inv) : st_reg.dir; // RULE17
  assign vel_min = st_reg.prof_min; // RULE5
  // Homing caps at its own velocity, joystick at the gear limit.
  assign vel_max = homing ? st_reg.home_vel : // RULE4
                   joy_run ? (joy_high_gear ? st_reg.jhi_vel : st_reg.jlo_vel) : // RULE16
                   st_reg.prof_max;
  assign accel = joy_run ? (joy_high_gear ? st_reg.jhi_acc : st_reg.jlo_acc) : // RULE16
                 st_reg.prof_acc; // RULE5
  // Indices above the top are clamped; joystick forces the trapezoid.
  assign bow_index = (bow > sahc_pkg::BOW_MAX) ? sahc_pkg::BOW_MAX : bow; // RULE19
  assign s_curve = (bow != 5'h00) && !joy_run; // RULE18 RULE19
  // The limit in the stored move direction, not the joystick's, stops the axis, except during the offset move.
  assign axis_stop = (st_reg.dir ? rev_act : fwd_act) && !(st_reg.ax == sahc_pkg::AX_OFFSET);
  assign pos_zero_load = 32'h0000_0000;
  assign pos_zero_strobe = st_reg.zero_strobe;

endmodule // sahc_axis

/* sahc_pkg.sv */
// Package of register map, field layouts, reset values and limits for the stepper axis control.
package sahc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HOME_VEL = 8'h04;
  localparam logic [7:0] OFF_HOME_OFS = 8'h08;
  localparam logic [7:0] OFF_PROF_MIN = 8'h0C;
  localparam logic [7:0] OFF_PROF_MAX = 8'h10;
  localparam logic [7:0] OFF_PROF_ACC = 8'h14;
  localparam logic [7:0] OFF_REL_DIST = 8'h18;
  localparam logic [7:0] OFF_ABS_POS = 8'h1C;
  localparam logic [7:0] OFF_STEPS_REV = 8'h20;
  localparam logic [7:0] OFF_GEARBOX = 8'h24;
  localparam logic [7:0] OFF_JOY_LO_VEL = 8'h28;
  localparam logic [7:0] OFF_JOY_HI_VEL = 8'h2C;
  localparam logic [7:0] OFF_JOY_LO_ACC = 8'h30;
  localparam logic [7:0] OFF_JOY_HI_ACC = 8'h34;
  localparam logic [7:0] OFF_CMD = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;
  localparam logic [7:0] OFF_PITCH = 8'h40;
  localparam logic [7:0] OFF_USTEP_CAL = 8'h44;
  localparam logic [7:0] OFF_PERSIST = 8'h48;

  // Control register field positions.
  localparam int CTRL_HOME_DIR = 0;
  localparam int CTRL_HOME_SW = 1;
  localparam int CTRL_FWD_LIM_LO = 2;
  localparam int CTRL_REV_LIM_LO = 4;
  localparam int CTRL_TRIG_LO = 6;
  localparam int CTRL_MOVE_LO = 8;
  localparam int CTRL_JOY_INV = 10;
  localparam int CTRL_BOW_LO = 11;
  localparam int CTRL_BOW_W = 5;

  // Command register bits.
  localparam int CMD_REL = 0;
  localparam int CMD_ABS = 1;
  localparam int CMD_HOME = 2;
  localparam int CMD_SAVE = 3;

  // Limits and the fixed microstep factor.
  localparam logic [31:0] STEPS_REV_MIN = 32'h0000_0001;
  localparam logic [31:0] STEPS_REV_MAX = 32'h0000_2710;
  localparam logic [31:0] GEARBOX_MIN = 32'h0000_0001;
  localparam logic [31:0] GEARBOX_MAX = 32'h0000_03E8;
  localparam logic [7:0] USTEP_FACTOR = 8'h80;
  localparam logic [4:0] BOW_MAX = 5'h12;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STEPS_REV_RESET = 32'h0000_00C8;
  localparam logic [31:0] GEARBOX_RESET = 32'h0000_0001;
  localparam logic [31:0] PITCH_RESET = 32'h0000_0001;

  // Trigger pulse length in cycles.
  localparam logic [7:0] TRIG_PULSE_CYC = 8'h0A;

  // Trigger modes.
  typedef enum logic [1:0] {TRIG_OFF, TRIG_IN, TRIG_INOUT, TRIG_OUT} sahc_trig_e;
  // Move kinds.
  typedef enum logic [1:0] {MOVE_REL, MOVE_ABS, MOVE_HOME, MOVE_RSV} sahc_move_e;
  // Limit switch sense.
  typedef enum logic [1:0] {SW_MAKES, SW_BREAKS, SW_IGNORE, SW_IGNORE2} sahc_sw_e;
  // Axis activity.
  typedef enum logic [1:0] {AX_IDLE, AX_MOVE, AX_SEEK, AX_OFFSET} sahc_ax_e;

endpackage : sahc_pkg

/* sahc_axis_chk.sv */
// Port checker for the axis control block, bound to its top module.
module sahc_axis_chk (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Watched ports.
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic trig_out,
  input wire logic nv_save,
  input wire logic move_start,
  input wire logic move_done,
  input wire logic joy_active,
  input wire logic s_curve,
  input wire logic [4:0] bow_index,
  input wire logic pos_zero_strobe,
  input wire logic [31:0] pos_zero_load
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // The bus never stalls and never reports an error.
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  start_once_a: assert property (move_start |=> !move_start)
    else $error("move start longer than one cycle");
  trig_len_a: assert property ($rose(trig_out) |->
    trig_out [*8] ##1 trig_out ##1 trig_out ##1 !trig_out)
    else $error("trigger pulse length wrong");
  // A pulse without a move start would wake other units for nothing.
  trig_cause_a: assert property ($rose(trig_out) |-> move_start || $past(move_start))
    else $error("trigger pulse without move start");
  joy_trap_a: assert property (joy_active |-> !s_curve)
    else $error("joystick move not trapezoidal");
  bow_range_a: assert property (bow_index <= 5'h12)
    else $error("bow index above range");
  scurve_bow_a: assert property (s_curve |-> bow_index != 5'h00)
    else $error("s-curve with zero bow index");
  zero_after_a: assert property (pos_zero_strobe |->
    $past(move_done) && pos_zero_load == 32'h0000_0000)
    else $error("home zero not after offset move");
  save_once_a: assert property (nv_save |=> !nv_save)
    else $error("save pulse longer than one cycle");
  home_cov: cover property (pos_zero_strobe);
  trig_cov: cover property ($rose(trig_out));
  joy_cov: cover property (joy_active && bow_index != 5'h00);
endmodule // sahc_axis_chk
bind sahc_axis sahc_axis_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp, .trig_out, .nv_save,
  .move_start, .move_done, .joy_active, .s_curve, .bow_index, .pos_zero_strobe, .pos_zero_load);

/* sahc_stage.sv */
// Behavioural stage model: limit switches and a trajectory generator.
module sahc_stage (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Moves from the axis control.
  input wire logic move_start,
  input wire logic [1:0] move_kind,
  input wire logic move_dir,
  output logic move_done,
  // Switch wiring and levels.
  input wire logic fwd_brk,
  input wire logic rev_brk,
  output logic fwd_limit_in,
  output logic rev_limit_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seek, dir, fwd_on, rev_on;
  int cnt;
  // A breaking switch reads low while touched, so the level is flipped.
  assign fwd_limit_in = fwd_on ^ fwd_brk;
  assign rev_limit_in = rev_on ^ rev_brk;
  // A seek reaches the switch in its direction after eight cycles; other moves end then.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {seek, dir, fwd_on, rev_on, move_done} <= 5'h00;
      cnt <= 0;
    end else begin
      move_done <= 1'b0;
      if (move_start) begin
        seek <= (move_kind == 2'h2);
        dir <= move_dir;
        cnt <= 8;
        if (move_kind != 2'h2) begin
          {fwd_on, rev_on} <= 2'h0;
        end
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1 && seek) begin
          {fwd_on, rev_on} <= {!dir, dir};
        end else if (cnt == 1) begin
          move_done <= 1'b1;
        end
      end
    end
  end
endmodule // sahc_stage

/* sahc_axis_tb.sv */
// Self-checking testbench of the axis control block.
module sahc_axis_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, trig_in = 0, rev_brk = 1;
  logic joy_active = 0, joy_dir = 0, joy_high_gear = 0, nv_valid = 0, d0, d1;
  logic [31:0] haddr = 0, hwdata = 0, nv_ctrl = 0, nv_home_vel = 0, rd, t1, vx, vn, ac;
  logic [31:0] hrdata, move_target, vel_min, vel_max, accel, pos_zero_load;
  logic [1:0] htrans = 0, move_kind, k0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] bow_index;
  logic hreadyout, hresp, trig_out, nv_save, move_start, move_dir, s_curve, move_done;
  logic axis_stop, pos_zero_strobe, fwd_limit_in, rev_limit_in;
  int fail_count = 0, checked = 0, n_st, n_tr, n_zero, n_sv;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and stage model.
  always #50 hclk = ~hclk;
  sahc_axis i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fwd_limit_in, .rev_limit_in, .trig_in,
    .trig_out, .joy_active, .joy_dir, .joy_high_gear, .nv_ctrl, .nv_home_vel, .nv_valid,
    .nv_save, .move_start, .move_kind, .move_target, .move_dir, .vel_min, .vel_max,
    .accel, .s_curve, .bow_index, .move_done, .axis_stop, .pos_zero_load, .pos_zero_strobe);
  sahc_stage i_stage (.hclk, .hresetn, .move_start, .move_kind, .move_dir, .move_done,
    .fwd_brk(1'b0), .rev_brk, .fwd_limit_in, .rev_limit_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  // One single transfer; the wait loops never assume a zero-wait slave.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  // Counts starts, trigger cycles, zero strobes and saves.
  task automatic watch(input int n);
    {n_st, n_tr, n_zero, n_sv} = '0;
    repeat (n) begin
      @(negedge hclk);
      if (move_start === 1'b1) begin
        if (n_st == 0) begin
          {k0, d0, vx, vn, ac} = {move_kind, move_dir, vel_max, vel_min, accel};
        end
        {t1, d1} = {move_target, move_dir};
        n_st++;
      end
      n_tr += int'(trig_out === 1'b1);
      n_zero += int'(pos_zero_strobe === 1'b1);
      n_sv += int'(nv_save === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(sahc_pkg::OFF_CTRL, sahc_pkg::CTRL_RESET);
    rchk(sahc_pkg::OFF_STATUS, 32'h0000_0048);
    rchk(sahc_pkg::OFF_STEPS_REV, sahc_pkg::STEPS_REV_RESET);
    rchk(sahc_pkg::OFF_GEARBOX, sahc_pkg::GEARBOX_RESET);
    rchk(sahc_pkg::OFF_PITCH, sahc_pkg::PITCH_RESET);
    rchk(sahc_pkg::OFF_USTEP_CAL, 32'h0000_6400);
    bus(1'b1, 8'h80, 32'hFFFF_FFFF);
    rchk(8'h80, 32'h0000_0000);
  endtask
  // Values just outside the ranges are refused, the upper range ends are taken.
  task automatic t_limits;
    bus(1'b1, sahc_pkg::OFF_STEPS_REV, 32'h0000_0000);
    bus(1'b1, sahc_pkg::OFF_GEARBOX, 32'h0000_0000);
    rchk(sahc_pkg::OFF_USTEP_CAL, 32'h0000_6400);
    bus(1'b1, sahc_pkg::OFF_STEPS_REV, 32'h0000_2711);
    bus(1'b1, sahc_pkg::OFF_GEARBOX, 32'h0000_03E9);
    rchk(sahc_pkg::OFF_STEPS_REV, 32'h0000_00C8);
    rchk(sahc_pkg::OFF_GEARBOX, 32'h0000_0001);
    bus(1'b1, sahc_pkg::OFF_STEPS_REV, 32'h0000_2710);
    bus(1'b1, sahc_pkg::OFF_GEARBOX, 32'h0000_03E8);
    rchk(sahc_pkg::OFF_USTEP_CAL, 32'h4C4B_4000);
  endtask
  task automatic t_home(input logic fwd);
    bus(1'b1, sahc_pkg::OFF_CTRL, fwd ? 32'h0000_0012 : 32'h0000_0011);
    bus(1'b1, sahc_pkg::OFF_HOME_VEL, 32'h0000_0300);
    bus(1'b1, sahc_pkg::OFF_HOME_OFS, {31'h0000_0280, fwd});
    bus(1'b1, sahc_pkg::OFF_PROF_MIN, 32'h0000_0010);
    bus(1'b1, sahc_pkg::OFF_PROF_MAX, 32'h0000_9000);
    bus(1'b1, sahc_pkg::OFF_PROF_ACC, 32'h0000_0070);
    bus(1'b1, sahc_pkg::OFF_CMD, 32'h0000_0004);
    watch(80);
    chk(n_st, 2);
    chk(k0, sahc_pkg::MOVE_HOME);
    chk(d0, !fwd);
    chk(vx, 32'h0000_0300);
    chk({vn[15:0], ac[15:0]}, {16'h0010, 16'h0070});
    chk(t1, {31'h0000_0280, fwd});
    chk({axis_stop, d1}, {1'b0, fwd});
    chk(n_zero, 1);
  endtask
  // Mode, move type, command (zero means the trigger pin), starts, pulse cycles.
  task automatic t_trig;
    int md[6] = '{0, 1, 2, 3, 0, 1};
    int ty[6] = '{0, 1, 0, 0, 0, 2};
    int cm[6] = '{0, 0, 0, 1, 2, 0};
    int es[6] = '{0, 1, 1, 1, 1, 2};
    int eh[6] = '{0, 0, 10, 10, 0, 0};
    bus(1'b1, sahc_pkg::OFF_REL_DIST, 32'h0000_1234);
    bus(1'b1, sahc_pkg::OFF_ABS_POS, 32'h0000_5678);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, sahc_pkg::OFF_CTRL, 32'h11 | 32'(md[i]) << 6 | 32'(ty[i]) << 8);
      if (cm[i] != 0) begin
        bus(1'b1, sahc_pkg::OFF_CMD, 32'(cm[i]));
        watch(60);
      end else begin
        fork
          begin
            trig_in <= 1'b1;
            repeat (4) @(posedge hclk);
            trig_in <= 1'b0;
          end
          watch(60);
        join
      end
      chk(n_st, es[i]);
      chk(n_tr, eh[i]);
      if (es[i] != 0) begin
        chk(k0, (cm[i] == 2) ? 2'h1 : 2'(ty[i]));
      end
      if (es[i] == 1) begin
        chk(t1, (k0 == 2'h1) ? 32'h0000_5678 : 32'h0000_1234);
      end
    end
  endtask
  task automatic t_save;
    bus(1'b1, sahc_pkg::OFF_CMD, 32'h0000_0008);
    watch(6);
    chk(n_sv, 1);
    nv_ctrl <= 32'h0000_2C51;
    nv_home_vel <= 32'h0000_0777;
    nv_valid <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(sahc_pkg::OFF_CTRL, 32'h0000_2C51);
    rchk(sahc_pkg::OFF_HOME_VEL, 32'h0000_0777);
  endtask
  // Restored control word holds bow index five and the joystick inversion.
  task automatic t_joy;
    bus(1'b1, sahc_pkg::OFF_JOY_LO_VEL, 32'h0000_0111);
    bus(1'b1, sahc_pkg::OFF_JOY_HI_VEL, 32'h0000_0222);
    bus(1'b1, sahc_pkg::OFF_JOY_LO_ACC, 32'h0000_0033);
    bus(1'b1, sahc_pkg::OFF_JOY_HI_ACC, 32'h0000_0044);
    @(negedge hclk);
    chk({s_curve, bow_index}, {1'b1, 5'h05});
    for (int g = 0; g < 4; g++) begin
      @(posedge hclk);
      {joy_active, joy_high_gear, joy_dir} <= {1'b1, 2'(g)};
      repeat (2) @(negedge hclk);
      chk(vel_max, g[1] ? 32'h0000_0222 : 32'h0000_0111);
      chk(accel, g[1] ? 32'h0000_0044 : 32'h0000_0033);
      chk(s_curve, 1'b0);
      chk(move_dir, !g[0]);
    end
    joy_active <= 1'b0;
    bus(1'b1, sahc_pkg::OFF_CTRL, 32'h0000_F811);
    @(negedge hclk);
    chk(bow_index, sahc_pkg::BOW_MAX);
    bus(1'b1, sahc_pkg::OFF_CTRL, 32'h0000_0021);
    @(negedge hclk);
    chk(s_curve, 1'b0);
    rchk(sahc_pkg::OFF_STATUS, 32'h0000_0008);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_limits;
    t_home(1'b0);
    t_home(1'b1);
    t_trig;
    t_save;
    t_joy;
    final_report;
  end
  // The run needs under a thousand cycles; this cuts a hang short.
  initial begin
    #3000000;
    fail_count++;
    final_report;
  end
endmodule // sahc_axis_tb
